// ==== verilog/hfu_pkg.sv ====
// Constants for the framer-side user port: frame layout, dividers, limits.
// Assumes a 100 MHz system clock and a 784 kbps serial frame stream.
package hfu_pkg;
   localparam int unsigned SYS_CLK_HZ = 100_000_000;
   localparam int unsigned BIT_RATE_HZ = 784_000;
   localparam int unsigned REF_CLK_HZ = 12_544_000;
   localparam int unsigned FAST_CLK_HZ = 25_088_000;
   // Source-clock edges (reference in central, fast clock in remote) per bit-clock half period
   localparam logic [4:0] CENT_HALF_EDGES =
      5'(REF_CLK_HZ / BIT_RATE_HZ / 2);
   localparam logic [4:0] REM_HALF_EDGES =
      5'(FAST_CLK_HZ / BIT_RATE_HZ / 2);
   localparam int unsigned FRAME_PERIOD_US = 6000;
   localparam int unsigned FRAME_NOM_BITS =
      FRAME_PERIOD_US * (BIT_RATE_HZ / 1000) / 1000;
   localparam logic [12:0] POS_FIRST = 13'h0001;
   localparam logic [12:0] SYNC_LAST = 13'h000E;
   localparam logic [12:0] LAST_NO_STUFF = 13'h125E;
   localparam logic [12:0] STUFF_FIRST = 13'h125F;
   localparam logic [12:0] LAST_STUFF = 13'h1262;
   localparam logic [2:0] LOSS_LIMIT = 3'h6;
   localparam int unsigned TFP_GAP = 3;
   localparam logic [3:0] TFP_HIST_RST = 4'hF;
   localparam logic [13:0] SYNC_WORD_DEF = 14'h0000;
endpackage

// ==== verilog/hfu_bit_clk.sv ====
// Bit clock generator: derives the 784 kHz bit clock, its edge enables,
// the halved reference clock and the half-rate enable.
// Assumes reference and fast clocks are sampled inputs well below mclk/2.
`timescale 1ns/100ps
module hfu_bit_clk
   import hfu_pkg::*;
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic central_mode_in,
   input wire logic line_ref_clk_in,
   input wire logic recovered_fast_clock_in,
   output logic bit_clock_out,
   output logic bit_rise_out,
   output logic bit_fall_out,
   output logic line_ref_clk_out,
   output logic half_rate_en_out
);
   typedef struct packed {
      logic ref_prev;
      logic fast_prev;
      logic ref_div;
      logic half_ph;
      logic [4:0] edge_cnt;
      logic bclk;
      logic rise;
      logic fall;
      logic half_en;
   } hfu_clk_st_t;

   hfu_clk_st_t st_r, st_nxt;
   logic src_edge;
   logic ref_src_edge;
   logic [4:0] half_edges;

   always_comb begin
      st_nxt = st_r;
      st_nxt.ref_prev = line_ref_clk_in;
      st_nxt.fast_prev = recovered_fast_clock_in;
      st_nxt.rise = 1'b0;
      st_nxt.fall = 1'b0;
      st_nxt.half_en = 1'b0;
      // Central: reference is the source; remote: the recovered clock
      src_edge = central_mode_in ? (line_ref_clk_in & ~st_r.ref_prev)
                                 : (recovered_fast_clock_in & ~st_r.fast_prev);
      half_edges = central_mode_in ? CENT_HALF_EDGES : REM_HALF_EDGES;
      if (!central_mode_in && src_edge) begin
         st_nxt.ref_div = ~st_r.ref_div;
      end
      ref_src_edge = central_mode_in ? src_edge
                                     : (src_edge & ~st_r.ref_div);
      if (ref_src_edge) begin
         st_nxt.half_ph = ~st_r.half_ph;
         st_nxt.half_en = st_r.half_ph;
      end
      if (src_edge) begin
         if (st_r.edge_cnt == half_edges - 5'h01) begin
            st_nxt.edge_cnt = 5'h00;
            st_nxt.bclk = ~st_r.bclk;
            st_nxt.rise = ~st_r.bclk;
            st_nxt.fall = st_r.bclk;
         end else begin
            st_nxt.edge_cnt = st_r.edge_cnt + 5'h01;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bit_clock_out = st_r.bclk;
   // Early ticks: the port loads on the very edge that moves the clock
   assign bit_rise_out = st_nxt.rise;
   assign bit_fall_out = st_nxt.fall;
   assign line_ref_clk_out = st_r.ref_div;
   assign half_rate_en_out = st_r.half_en;
endmodule

// ==== verilog/hfu_user_port.sv ====
// Framer-side user port: serial receive/transmit payload with frame
// pulse, frame/stuff flag, sync-word loss flag and mode-dependent clocks.
// Assumes all inputs are synchronous to mclk_in; line-side data and the
// activation state come from the transceiver core.
`timescale 1ns/100ps

// What this block does
// - Frame/stuff flag high over the 14 sync bits, 18 bits in a stuffed frame
// - Remote mode: reference out is fast/2
// - Mode select high central, low remote
// - Bit clock 784 kHz from mode source
// - Loss flag rises after six bad syncs
// - Loss flag high when not active
// - Receive data all ones when inactive
// - Serial 784 kbps frames, sync and stuff
// - Frame pulse low on last frame bit
// - Frame pulses six milliseconds apart
// - Frame pulse valid once loss falls
// - Stuff-position transmit bits are dummies
// - Two low pulses three apart tri-state
// - Remote loop number valid with sync
module hfu_user_port
   import hfu_pkg::*;
#(
   parameter logic [13:0] SYNC_WORD = SYNC_WORD_DEF
)
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic central_mode_select_in,
   input wire logic line_ref_clk_in,
   output logic line_ref_clk_out,
   output logic line_ref_clk_oe_n_out,
   input wire logic recovered_fast_clock_in,
   input wire logic link_active_in,
   input wire logic rx_line_data_in,
   input wire logic rx_line_stuff_in,
   input wire logic rx_line_loop2_in,
   input wire logic tx_data_in,
   input wire logic tx_frame_pulse_n_in,
   output logic tx_line_data_out,
   output logic rx_data_out,
   output logic rx_frame_pulse_n_out,
   output logic rx_frame_stuff_flag_out,
   output logic bit_clock_out,
   output logic half_rate_clock_enable_out,
   output logic sync_word_loss_flag_out,
   output logic port_oe_n_out,
   input wire logic loop_number_in,
   output logic loop_number_out,
   output logic loop_number_oe_n_out,
   output logic loop2_selected_out
);
   typedef struct packed {
      logic [12:0] pos;
      logic stuff;
      logic [13:0] sync_sh;
      logic [2:0] miss_cnt;
      logic loss;
      logic act_prev;
      logic rx_data;
      logic rfp_n;
      logic rx_frame_stuff_flag;
      logic tx_data;
      logic [3:0] tfp_hist;
      logic tri_st;
      logic loop_num;
   } hfu_port_st_t;

   hfu_port_st_t st_r, st_nxt;
   logic bit_rise;
   logic bit_fall;
   logic [12:0] last_pos;
   logic [13:0] word;

   function automatic logic is_overhead(input logic [12:0] p);
      is_overhead = (p <= SYNC_LAST) || (p >= STUFF_FIRST);
   endfunction

   hfu_bit_clk u_bit_clk (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .central_mode_in(central_mode_select_in),
      .line_ref_clk_in(line_ref_clk_in),
      .recovered_fast_clock_in(recovered_fast_clock_in),
      .bit_clock_out(bit_clock_out),
      .bit_rise_out(bit_rise),
      .bit_fall_out(bit_fall),
      .line_ref_clk_out(line_ref_clk_out),
      .half_rate_en_out(half_rate_clock_enable_out)
   );

   always_comb begin
      st_nxt = st_r;
      last_pos = st_r.stuff ? LAST_STUFF : LAST_NO_STUFF;
      word = {st_r.sync_sh[12:0], rx_line_data_in};
      st_nxt.act_prev = link_active_in;
      // Receive side advances on the falling bit-clock edge only
      if (bit_fall) begin
         if (st_r.pos == last_pos) begin
            st_nxt.pos = POS_FIRST;
         end else begin
            st_nxt.pos = st_r.pos + 13'h0001;
         end
         if (st_r.pos == LAST_NO_STUFF) begin
            st_nxt.stuff = rx_line_stuff_in;
         end
         // All three receive outputs load together
         st_nxt.rx_data = link_active_in ? rx_line_data_in : 1'b1;
         st_nxt.rfp_n = ~(st_r.pos == last_pos);
         st_nxt.rx_frame_stuff_flag = is_overhead(st_r.pos);
         if (st_r.pos <= SYNC_LAST) begin
            st_nxt.sync_sh = word;
         end
         if (link_active_in && st_r.pos == SYNC_LAST) begin
            if (word != SYNC_WORD) begin
               if (st_r.miss_cnt == LOSS_LIMIT - 3'h1) begin
                  st_nxt.loss = 1'b1;
                  st_nxt.miss_cnt = LOSS_LIMIT;
               end else if (st_r.miss_cnt != LOSS_LIMIT) begin
                  st_nxt.miss_cnt = st_r.miss_cnt + 3'h1;
               end
            end else begin
               // Frame pulse is trustworthy from this fall on
               st_nxt.miss_cnt = 3'h0;
               st_nxt.loss = 1'b0;
               st_nxt.loop_num = rx_line_loop2_in;
            end
         end
      end
      if (!link_active_in) begin
         st_nxt.loss = 1'b1;
         st_nxt.miss_cnt = 3'h0;
      end else if (!st_r.act_prev) begin
         st_nxt.loss = 1'b0;
      end
      if (bit_rise) begin
         // Passed through untouched, stuff dummies included
         st_nxt.tx_data = tx_data_in;
         st_nxt.tfp_hist = {st_r.tfp_hist[2:0], tx_frame_pulse_n_in};
         if (!tx_frame_pulse_n_in && !st_r.tfp_hist[TFP_GAP - 1]) begin
            st_nxt.tri_st = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         st_r <= '0;
         st_r.pos <= POS_FIRST;
         st_r.loss <= 1'b1;
         st_r.rx_data <= 1'b1;
         st_r.rfp_n <= 1'b1;
         st_r.tfp_hist <= TFP_HIST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Tri-state stays until reset; a stray double pulse needs a reset
   assign port_oe_n_out = st_r.tri_st;
   assign rx_data_out = st_r.rx_data;
   assign rx_frame_pulse_n_out = st_r.rfp_n;
   assign rx_frame_stuff_flag_out = st_r.rx_frame_stuff_flag;
   assign sync_word_loss_flag_out = st_r.loss;
   assign tx_line_data_out = st_r.tx_data;
   assign line_ref_clk_oe_n_out = central_mode_select_in;
   assign loop_number_out = st_r.loop_num;
   assign loop_number_oe_n_out = central_mode_select_in;
   assign loop2_selected_out = central_mode_select_in ? loop_number_in
                                                      : st_r.loop_num;
endmodule

// ==== testbench/hfu_port_properties.sv ====
// Timing checker for the user port, bound to its top module.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module hfu_port_props (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic central_mode_select_in,
   input wire logic recovered_fast_clock_in,
   input wire logic link_active_in,
   input wire logic tx_data_in,
   input wire logic line_ref_clk_out,
   input wire logic line_ref_clk_oe_n_out,
   input wire logic loop_number_oe_n_out,
   input wire logic rx_data_out,
   input wire logic rx_frame_pulse_n_out,
   input wire logic rx_frame_stuff_flag_out,
   input wire logic bit_clock_out,
   input wire logic sync_word_loss_flag_out,
   input wire logic port_oe_n_out,
   input wire logic tx_line_data_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   property p_ref_div;
      $rose(recovered_fast_clock_in) && !central_mode_select_in
         |-> ##[1:2] $changed(line_ref_clk_out);
   endproperty
   a_ref_div: assert property (p_ref_div) else $error("ref not halved");
   property p_oe_mode;
      line_ref_clk_oe_n_out == central_mode_select_in
         && loop_number_oe_n_out == central_mode_select_in;
   endproperty
   a_oe_mode: assert property (p_oe_mode) else $error("mode pin dir");
   property p_rx_inact;
      $fell(bit_clock_out) && !$past(link_active_in) |-> rx_data_out;
   endproperty
   a_rx_inact: assert property (p_rx_inact) else $error("rx not ones");
   property p_loss_inact;
      !link_active_in |=> sync_word_loss_flag_out;
   endproperty
   a_loss_inact: assert property (p_loss_inact) else $error("loss low");
   property p_loss_act;
      $rose(link_active_in) |=> !sync_word_loss_flag_out;
   endproperty
   a_loss_act: assert property (p_loss_act) else $error("loss stuck");
   // Framer samples on the rise, so all three must move together
   property p_same_edge;
      $changed(rx_data_out) || $changed(rx_frame_pulse_n_out)
         || $changed(rx_frame_stuff_flag_out) |-> $fell(bit_clock_out);
   endproperty
   a_same_edge: assert property (p_same_edge) else $error("rx skew");
   property p_oe_sticky;
      port_oe_n_out |=> port_oe_n_out;
   endproperty
   a_oe_sticky: assert property (p_oe_sticky) else $error("oe drop");
   property p_pass;
      $rose(bit_clock_out) |=> tx_line_data_out == $past(tx_data_in, 2);
   endproperty
   a_pass: assert property (p_pass) else $error("tx not passed");
endmodule
bind hfu_user_port hfu_port_props i_props (.*);

// ==== testbench/hfu_framer_model.sv ====
// Framer model: random transmit bits, frame pulse on command.
// Assumes it sees the bit clock; cmd 1 one pulse, 2 two pulses 3 apart.
`timescale 1ns/100ps
module hfu_framer_model (
   input wire logic mclk_in,
   input wire logic bit_clock_in,
   input wire logic [1:0] fp_cmd_in,
   output logic tx_data_out,
   output logic tx_frame_pulse_n_out
);
   logic prev = 1'b0;
   int n = 0;
   initial begin
      tx_data_out = 1'b1;
      tx_frame_pulse_n_out = 1'b1;
   end
   // Change one edge after the fall; bench drives cmd on the other edge
   always @(posedge mclk_in) begin
      if (prev && !bit_clock_in) begin
         tx_data_out <= 1'($urandom);
         n <= (fp_cmd_in == 2'h0) ? 0 : n + 1;
         tx_frame_pulse_n_out <= !(n == 1 || (fp_cmd_in == 2'h2 && n == 4));
      end
      prev <= bit_clock_in;
   end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the framer-side user port.
// Assumes source clocks are driven as data from the bench.
`timescale 1ns/100ps
module testbench;
   logic mclk_in, sys_rst_in, central_mode_select_in, line_ref_clk_in;
   logic recovered_fast_clock_in, link_active_in, rx_line_data_in;
   logic rx_line_stuff_in, rx_line_loop2_in, loop_number_in, act;
   logic tx_data_in, tx_frame_pulse_n_in, line_ref_clk_out;
   logic line_ref_clk_oe_n_out, tx_line_data_out, rx_data_out;
   logic rx_frame_pulse_n_out, rx_frame_stuff_flag_out, bit_clock_out;
   logic half_rate_clock_enable_out, sync_word_loss_flag_out;
   logic port_oe_n_out, loop_number_out, loop_number_oe_n_out;
   logic loop2_selected_out;
   logic [1:0] fp_cmd;
   int n_mismatch = 0, check_count = 0, cyc = 0;
   time t_prev = 0;
   hfu_user_port #(.SYNC_WORD(14'h2C35)) i_dut (.*);
   hfu_framer_model i_framer (.mclk_in(mclk_in),
      .bit_clock_in(bit_clock_out), .fp_cmd_in(fp_cmd),
      .tx_data_out(tx_data_in), .tx_frame_pulse_n_out(tx_frame_pulse_n_in));
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   // Both sources at a quarter of mclk, well inside sampling range
   always @(negedge mclk_in) begin
      cyc <= cyc + 1;
      line_ref_clk_in <= cyc[1];
      recovered_fast_clock_in <= cyc[1];
      {loop_number_in, rx_line_stuff_in, rx_line_loop2_in} <= 3'($urandom);
   end
   function automatic logic exp_rx(logic a, logic d);
      return a ? d : 1'b1;
   endfunction
   function automatic logic exp_flag(int pos);
      return pos >= 1 && pos <= 14;
   endfunction
   task automatic chk(string name, logic exp, logic got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s exp %b got %b", name, exp, got);
      end
   endtask
   task automatic chk_t(string name, int exp, int got);
      check_count++;
      if (got != exp) begin
         n_mismatch++;
         $display("BAD %s exp %0d got %0d", name, exp, got);
      end
   endtask
   task automatic step(logic a, logic md, logic [1:0] cmd);
      @(negedge mclk_in);
      rx_line_data_in = 1'($urandom);
      link_active_in = a;
      central_mode_select_in = md;
      fp_cmd = cmd;
      @(negedge bit_clock_out);
      #1;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      summarize();
   end
   initial begin
      void'($urandom(97));
      {sys_rst_in, central_mode_select_in, act} = 3'h6;
      {link_active_in, rx_line_data_in, fp_cmd} = 4'h0;
      {line_ref_clk_in, recovered_fast_clock_in} = 2'h0;
      {loop_number_in, rx_line_stuff_in, rx_line_loop2_in} = 3'h0;
      repeat (3) @(negedge mclk_in);
      sys_rst_in = 1'b0;
      chk("loss", 1'b1, sync_word_loss_flag_out);
      chk("rdata", 1'b1, rx_data_out);
      for (int i = 1; i <= 40; i++) begin
         act = (i < 20) ? 1'b1 : 1'($urandom);
         step(act, i < 30, 2'h0);
         chk("rdata", exp_rx(act, rx_line_data_in), rx_data_out);
         chk("flag", exp_flag(i), rx_frame_stuff_flag_out);
         chk("rfp_n", 1'b1, rx_frame_pulse_n_out);
         if (i > 1 && i != 30)
            chk_t("bit_period", (i < 30) ?
               80 * int'(hfu_pkg::CENT_HALF_EDGES) :
               80 * int'(hfu_pkg::REM_HALF_EDGES),
               int'($time - t_prev));
         t_prev = $time;
         if (!act) chk("loss", 1'b1, sync_word_loss_flag_out);
         chk("ref_oe", central_mode_select_in, line_ref_clk_oe_n_out);
      end
      // A single pulse must not float the port
      repeat (8) step(1'b1, 1'b0, 2'h1);
      chk("oe_n", 1'b0, port_oe_n_out);
      step(1'b1, 1'b0, 2'h0);
      repeat (8) step(1'b1, 1'b0, 2'h2);
      chk("oe_n", 1'b1, port_oe_n_out);
      summarize();
   end
endmodule
